// >>> common/pos_window_pkg.sv
// constants shared by the position window block
package pos_window_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int POS_W = 32;
    localparam int NUM_WIN = 8;
    localparam int SEL_W = 3;

    // ****************************************
    // selector and mode encodings
    // ****************************************
    localparam logic SRC_FEEDBACK = 1'h0;
    localparam logic SRC_COMMAND = 1'h1;
    localparam logic MODE_ABSOLUTE = 1'h0;
    localparam logic MODE_RELATIVE = 1'h1;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic signed [POS_W-1:0] BOUND_RESET = 32'h0000_0000;
    localparam logic MODE_RESET = MODE_ABSOLUTE;
    localparam logic SRC_RESET = SRC_FEEDBACK;
    localparam logic OUT_RESET = 1'h0;

endpackage

// >>> hw/window_compare.sv
// one position window comparator, combinational
`timescale 1ns/1ps
module window_compare
    import pos_window_pkg::*;
(
    input wire logic signed [POS_W-1:0] feedback_pos,
    input wire logic signed [POS_W-1:0] command_pos,
    input wire logic signed [POS_W-1:0] target_pos,
    input wire logic signed [POS_W-1:0] bound_pos,
    input wire logic signed [POS_W-1:0] bound_neg,
    input wire logic range_mode,
    input wire logic pos_src,
    output logic hit
);
    logic signed [POS_W-1:0] sel_pos;
    logic signed [POS_W-1:0] edge_a;
    logic signed [POS_W-1:0] edge_b;
    logic signed [POS_W-1:0] lo;
    logic signed [POS_W-1:0] hi;

    always_comb begin
        sel_pos = (pos_src == SRC_COMMAND) ? command_pos : feedback_pos;
        if (range_mode == MODE_RELATIVE) begin
            // offset from target, then width from that point; wraps like the counters
            edge_a = target_pos + bound_pos;
            edge_b = edge_a + bound_neg;
        end else begin
            edge_a = bound_pos;
            edge_b = bound_neg;
        end
        lo = (edge_a < edge_b) ? edge_a : edge_b;
        hi = (edge_a < edge_b) ? edge_b : edge_a;
        hit = (sel_pos >= lo) && (sel_pos <= hi);
    end
endmodule // window_compare

// >>> hw/pos_window_top.sv
// eight position window status outputs with their settings
// ****************************************
// Summary of operation
// - per output: 0 feedback, 1 command position
// - mode 0 absolute, 1 offset/width from target
// - first parameter: positive bound or target offset
// - second parameter: negative bound or width
// - all settings reset to zero
// ****************************************
`timescale 1ns/1ps
module pos_window_top
    import pos_window_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic signed [POS_W-1:0] feedback_pos,
    input wire logic signed [POS_W-1:0] command_pos,
    input wire logic signed [POS_W-1:0] target_pos,
    input wire logic cfg_wr,
    input wire logic [SEL_W-1:0] cfg_sel,
    input wire logic signed [POS_W-1:0] cfg_bound_pos,
    input wire logic signed [POS_W-1:0] cfg_bound_neg,
    input wire logic cfg_range_mode,
    input wire logic cfg_pos_src,
    output logic position_window_out_0,
    output logic position_window_out_1,
    output logic position_window_out_2,
    output logic position_window_out_3,
    output logic position_window_out_4,
    output logic position_window_out_5,
    output logic position_window_out_6,
    output logic position_window_out_7
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [NUM_WIN-1:0][POS_W-1:0] bound_pos;
        logic [NUM_WIN-1:0][POS_W-1:0] bound_neg;
        logic [NUM_WIN-1:0] range_mode;
        logic [NUM_WIN-1:0] pos_src;
        logic [NUM_WIN-1:0] win_out;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic [NUM_WIN-1:0] hit;

    // ****************************************
    // comparators
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WIN; gi++) begin : g_win
            window_compare u_cmp (
                .feedback_pos(feedback_pos),
                .command_pos(command_pos),
                .target_pos(target_pos),
                .bound_pos(st_reg.bound_pos[gi]),
                .bound_neg(st_reg.bound_neg[gi]),
                .range_mode(st_reg.range_mode[gi]),
                .pos_src(st_reg.pos_src[gi]),
                .hit(hit[gi])
            );
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        if (cfg_wr) begin
            st_next.bound_pos[cfg_sel] = cfg_bound_pos;
            st_next.bound_neg[cfg_sel] = cfg_bound_neg;
            st_next.range_mode[cfg_sel] = cfg_range_mode;
            st_next.pos_src[cfg_sel] = cfg_pos_src;
        end
        st_next.win_out = hit;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.bound_pos <= {NUM_WIN{BOUND_RESET}};
            st_reg.bound_neg <= {NUM_WIN{BOUND_RESET}};
            st_reg.range_mode <= {NUM_WIN{MODE_RESET}};
            st_reg.pos_src <= {NUM_WIN{SRC_RESET}};
            st_reg.win_out <= {NUM_WIN{OUT_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign position_window_out_0 = st_reg.win_out[0];
    assign position_window_out_1 = st_reg.win_out[1];
    assign position_window_out_2 = st_reg.win_out[2];
    assign position_window_out_3 = st_reg.win_out[3];
    assign position_window_out_4 = st_reg.win_out[4];
    assign position_window_out_5 = st_reg.win_out[5];
    assign position_window_out_6 = st_reg.win_out[6];
    assign position_window_out_7 = st_reg.win_out[7];

    // ****************************************
    // checks
    // ****************************************
    a_reset_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(arst_n) |-> (st_reg.bound_pos == '0) && (st_reg.bound_neg == '0)
            && (st_reg.range_mode == '0) && (st_reg.pos_src == '0))
        else $error("settings not zero after reset");

    a_out_reset: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(arst_n) |-> (st_reg.win_out == '0))
        else $error("window outputs not low after reset");

    generate
        for (gi = 0; gi < NUM_WIN; gi++) begin : g_chk
            a_cfg_store: assert property (@(posedge core_clk) disable iff (!arst_n)
                cfg_wr && (cfg_sel == gi) |=>
                    (st_reg.range_mode[gi] == $past(cfg_range_mode))
                    && (st_reg.pos_src[gi] == $past(cfg_pos_src))
                    && (st_reg.bound_pos[gi] == $past(cfg_bound_pos))
                    && (st_reg.bound_neg[gi] == $past(cfg_bound_neg)))
                else $error("window setting not stored");

            a_abs_inside: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_ABSOLUTE) && (st_reg.pos_src[gi] == SRC_FEEDBACK)
                    && ($signed(st_reg.bound_neg[gi]) <= feedback_pos)
                    && (feedback_pos <= $signed(st_reg.bound_pos[gi]))
                    |=> st_reg.win_out[gi])
                else $error("absolute window missed feedback position");

            a_abs_outside: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_ABSOLUTE) && (st_reg.pos_src[gi] == SRC_FEEDBACK)
                    && (feedback_pos > $signed(st_reg.bound_pos[gi]))
                    && (feedback_pos > $signed(st_reg.bound_neg[gi]))
                    |=> !st_reg.win_out[gi])
                else $error("absolute window hit outside range");

            a_src_command: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_ABSOLUTE) && (st_reg.pos_src[gi] == SRC_COMMAND)
                    && (st_reg.bound_pos[gi] == st_reg.bound_neg[gi])
                    |=> (st_reg.win_out[gi] == ($past(command_pos) == $past(st_reg.bound_pos[gi]))))
                else $error("command position source not honoured");

            a_rel_offset: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_RELATIVE) && (st_reg.pos_src[gi] == SRC_FEEDBACK)
                    && (st_reg.bound_neg[gi] == '0)
                    |=> (st_reg.win_out[gi] ==
                        ($past(feedback_pos) == $past(target_pos) + $past(st_reg.bound_pos[gi]))))
                else $error("relative offset point wrong");

            a_abs_below: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_ABSOLUTE) && (st_reg.pos_src[gi] == SRC_FEEDBACK)
                    && (feedback_pos < $signed(st_reg.bound_pos[gi]))
                    && (feedback_pos < $signed(st_reg.bound_neg[gi]))
                    |=> !st_reg.win_out[gi])
                else $error("absolute window hit below range");

            a_swap_inside: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_ABSOLUTE) && (st_reg.pos_src[gi] == SRC_FEEDBACK)
                    && ($signed(st_reg.bound_pos[gi]) <= feedback_pos)
                    && (feedback_pos <= $signed(st_reg.bound_neg[gi]))
                    |=> st_reg.win_out[gi])
                else $error("swapped bounds window missed position");

            a_cmd_inside: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_ABSOLUTE) && (st_reg.pos_src[gi] == SRC_COMMAND)
                    && ($signed(st_reg.bound_neg[gi]) <= command_pos)
                    && (command_pos <= $signed(st_reg.bound_pos[gi]))
                    |=> st_reg.win_out[gi])
                else $error("absolute window missed command position");

            a_cmd_outside: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_ABSOLUTE) && (st_reg.pos_src[gi] == SRC_COMMAND)
                    && (command_pos > $signed(st_reg.bound_pos[gi]))
                    && (command_pos > $signed(st_reg.bound_neg[gi]))
                    |=> !st_reg.win_out[gi])
                else $error("command window hit above range");

            a_cmd_below: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_ABSOLUTE) && (st_reg.pos_src[gi] == SRC_COMMAND)
                    && (command_pos < $signed(st_reg.bound_pos[gi]))
                    && (command_pos < $signed(st_reg.bound_neg[gi]))
                    |=> !st_reg.win_out[gi])
                else $error("command window hit below range");

            a_rel_start: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_RELATIVE) && (st_reg.pos_src[gi] == SRC_FEEDBACK)
                    && (feedback_pos == $signed(target_pos + st_reg.bound_pos[gi]))
                    |=> st_reg.win_out[gi])
                else $error("relative window missed offset point");

            a_rel_end: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_RELATIVE) && (st_reg.pos_src[gi] == SRC_FEEDBACK)
                    && (feedback_pos ==
                        $signed(target_pos + st_reg.bound_pos[gi] + st_reg.bound_neg[gi]))
                    |=> st_reg.win_out[gi])
                else $error("relative window missed far end");

            a_rel_beyond: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_RELATIVE) && (st_reg.pos_src[gi] == SRC_FEEDBACK)
                    && (feedback_pos > $signed(target_pos + st_reg.bound_pos[gi]))
                    && (feedback_pos >
                        $signed(target_pos + st_reg.bound_pos[gi] + st_reg.bound_neg[gi]))
                    |=> !st_reg.win_out[gi])
                else $error("relative window hit beyond range");

            a_rel_cmd: assert property (@(posedge core_clk) disable iff (!arst_n)
                (st_reg.range_mode[gi] == MODE_RELATIVE) && (st_reg.pos_src[gi] == SRC_COMMAND)
                    && (command_pos == $signed(target_pos + st_reg.bound_pos[gi]))
                    |=> st_reg.win_out[gi])
                else $error("relative window missed command offset");

            a_cfg_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
                !(cfg_wr && (cfg_sel == gi)) |=>
                    $stable(st_reg.range_mode[gi]) && $stable(st_reg.pos_src[gi])
                    && $stable(st_reg.bound_pos[gi]) && $stable(st_reg.bound_neg[gi]))
                else $error("window setting changed without write");
        end
    endgenerate
endmodule // pos_window_top

// >>> dv/pos_window_host.sv
// host side model: reads the eight window outputs as one status word
`timescale 1ns/1ps
module pos_window_host (
    input wire logic win_0,
    input wire logic win_1,
    input wire logic win_2,
    input wire logic win_3,
    input wire logic win_4,
    input wire logic win_5,
    input wire logic win_6,
    input wire logic win_7,
    output logic [7:0] status
);
    assign status = {win_7, win_6, win_5, win_4, win_3, win_2, win_1, win_0};
endmodule // pos_window_host

// >>> dv/pos_window_top_tb.sv
// self-checking bench for the position window block
`timescale 1ns/1ps
module pos_window_top_tb;
    import pos_window_pkg::*;
    logic core_clk, arst_n, cfg_wr, cfg_range_mode, cfg_pos_src;
    logic [SEL_W-1:0] cfg_sel;
    logic signed [POS_W-1:0] feedback_pos, command_pos, target_pos, cfg_bound_pos, cfg_bound_neg;
    wire [7:0] win;
    logic [7:0] status;
    logic signed [POS_W-1:0] bp_t [NUM_WIN];
    logic signed [POS_W-1:0] bn_t [NUM_WIN];
    logic md_t [NUM_WIN];
    logic sr_t [NUM_WIN];
    int num_errors = 0;
    int samples_checked = 0;

    pos_window_top i_pos_window_top (.core_clk(core_clk), .arst_n(arst_n),
        .feedback_pos(feedback_pos), .command_pos(command_pos), .target_pos(target_pos),
        .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_bound_pos(cfg_bound_pos),
        .cfg_bound_neg(cfg_bound_neg), .cfg_range_mode(cfg_range_mode),
        .cfg_pos_src(cfg_pos_src), .position_window_out_0(win[0]),
        .position_window_out_1(win[1]), .position_window_out_2(win[2]),
        .position_window_out_3(win[3]), .position_window_out_4(win[4]),
        .position_window_out_5(win[5]), .position_window_out_6(win[6]),
        .position_window_out_7(win[7]));
    pos_window_host i_pos_window_host (.win_0(win[0]), .win_1(win[1]), .win_2(win[2]),
        .win_3(win[3]), .win_4(win[4]), .win_5(win[5]), .win_6(win[6]), .win_7(win[7]),
        .status(status));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ****************************************
    // reference and access tasks
    // ****************************************
    function automatic logic exp_hit(int i);
        logic signed [POS_W-1:0] a, b, p;
        a = md_t[i] ? target_pos + bp_t[i] : bp_t[i];
        b = md_t[i] ? a + bn_t[i] : bn_t[i];
        p = sr_t[i] ? command_pos : feedback_pos;
        return (a <= b) ? (p >= a && p <= b) : (p >= b && p <= a);
    endfunction

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check_all(string name);
        logic [7:0] e;
        for (int i = 0; i < NUM_WIN; i++) e[i] = exp_hit(i);
        check(name, status, e);
    endtask

    // write held high across back-to-back calls
    task automatic write_win(int i, logic signed [POS_W-1:0] bp, logic signed [POS_W-1:0] bn);
        cfg_wr = 1'b1;
        cfg_sel = SEL_W'(i);
        cfg_bound_pos = bp;
        cfg_bound_neg = bn;
        cfg_range_mode = i[0];
        cfg_pos_src = i[1];
        bp_t[i] = bp;
        bn_t[i] = bn;
        md_t[i] = i[0];
        sr_t[i] = i[1];
        @(negedge core_clk);
    endtask

    task automatic clear_model();
        for (int i = 0; i < NUM_WIN; i++) begin
            bp_t[i] = '0;
            bn_t[i] = '0;
            md_t[i] = MODE_RESET;
            sr_t[i] = SRC_RESET;
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        arst_n = 1'b0;
        {cfg_wr, cfg_range_mode, cfg_pos_src, cfg_sel} = '0;
        {cfg_bound_pos, cfg_bound_neg, command_pos, target_pos} = '0;
        feedback_pos = 32'sh0000_0005;
        clear_model();
        repeat (8) @(negedge core_clk);
        check("reset_out", status, 8'h00);
        arst_n = 1'b1;
        @(negedge core_clk);
        check_all("reset_settings_off");
        feedback_pos = '0;
        @(negedge core_clk);
        check_all("reset_settings_on");
        for (int i = 0; i < NUM_WIN; i++) begin
            if (i == 6) write_win(i, 32'sh7FFF_FFFF, 32'sh8000_0000);
            else write_win(i, 6 - i, i - 4);
        end
        cfg_wr = 1'b0;
        target_pos = 32'sh0000_0002;
        @(negedge core_clk);
        for (int k = -12; k <= 12; k++) begin
            feedback_pos = k;
            command_pos = -k;
            @(negedge core_clk);
            check_all("window_sweep");
        end
        write_win(2, 3, 3);
        write_win(5, 4, 0);
        cfg_wr = 1'b0;
        for (int k = 2; k <= 7; k++) begin
            feedback_pos = k;
            command_pos = k;
            @(negedge core_clk);
            check_all("point_windows");
        end
        arst_n = 1'b0;
        @(negedge core_clk);
        check("mid_reset_out", status, 8'h00);
        clear_model();
        arst_n = 1'b1;
        feedback_pos = '0;
        command_pos = 32'sh0000_0007;
        @(negedge core_clk);
        check_all("second_reset");
        stop_test();
    end

    initial begin
        #20000;
        num_errors++;
        stop_test();
    end
endmodule // pos_window_top_tb
